//--- logic/adc_mode_defines.svh
// Purpose: Offsets, field positions, reset value and timing counts of the mode control block
// Assumes: pclk at 25 MHz (40 ns period)
// Notes: Overview list below
// Overview of operation
// - Any write to the mode register restarts filter, clears ready, starts conversion unless it selects standby or power-down.
// - Mode register at index 0x01, 16 bits, resets to 0x2000.
// - Bit 15 enables internal reference and buffered 2.5 V output.
// - Bit 13 set with one channel: output only fully settled results; resets 1.
// - Field [10:8] sets channel-switch delay 0/8/32/80/200/400 us, 1/2 ms.
// - Field [6:4] selects continuous, single, standby, power-down or four calibrations.
// - Field [3:2] selects internal, internal-out, external clock or crystal.
// - Internal oscillator choice also turns the oscillator on.
`ifndef ADC_MODE_DEFINES_SVH
`define ADC_MODE_DEFINES_SVH
`define MODE_REG_INDEX 8'h01
`define MODE_REG_ADDR 12'h004
`define MODE_REG_RESET 16'h2000
`define MODE_WRITE_MASK 16'hE77C
`define BIT_REF_EN 15
`define BIT_SETTLED 13
`define FLD_DELAY_HI 10
`define FLD_DELAY_LO 8
`define FLD_MODE_HI 6
`define FLD_MODE_LO 4
`define FLD_CLK_HI 3
`define FLD_CLK_LO 2
`define CLK_MHZ 25
`define DLY_US_1 8
`define DLY_US_2 32
`define DLY_US_3 80
`define DLY_US_4 200
`define DLY_US_5 400
`define DLY_US_6 1000
`define DLY_US_7 2000
`endif

//--- logic/adc_mode_pkg.sv
// Purpose: Types of the mode control block
// Assumes: nothing
// Notes: codes follow the mode field
package adc_mode_pkg;
	typedef enum logic [2:0] {
		MODE_CONT = 3'h0, MODE_SINGLE = 3'h1, MODE_STANDBY = 3'h2, MODE_PWRDN = 3'h3,
		MODE_INT_OFS = 3'h4, MODE_INT_GAIN = 3'h5, MODE_SYS_OFS = 3'h6, MODE_SYS_GAIN = 3'h7
	} op_mode_t;
	typedef enum logic [1:0] {
		CLK_INT = 2'h0, CLK_INT_OUT = 2'h1, CLK_EXT = 2'h2, CLK_XTAL = 2'h3
	} clk_src_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_SETTLE = 4'h2, ST_CONVERT = 4'h4, ST_DONE = 4'h8
	} seq_state_t;
endpackage

//--- logic/settle_timer_if.sv
// Purpose: Carrier between the sequencer and the settle timer
// Assumes: single pclk domain
// Notes: load pulses start a count; busy stays high until it expires
`timescale 1ns/1ps
interface settle_timer_if;
	logic load;
	logic [2:0] code;
	logic busy;
	modport ctrl (output load, output code, input busy);
	modport timer (input load, input code, output busy);
endinterface

//--- logic/settle_timer.sv
// Purpose: Counts the post channel-switch settling delay on the master clock
// Assumes: pclk is the master clock used for counting
// Notes: counts derived from microsecond figures and the clock rate
`timescale 1ns/1ps
`include "adc_mode_defines.svh"
module settle_timer
	import adc_mode_pkg::*;
(
	input wire logic pclk, // Master clock
	input wire logic presetn, // Async reset, active low
	settle_timer_if.timer tif // Load and busy
);
	localparam int CW = 16;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] load_val;

	always_comb begin
		unique case (tif.code)
			3'h0: load_val = 16'h0000;
			3'h1: load_val = CW'(`DLY_US_1 * `CLK_MHZ);
			3'h2: load_val = CW'(`DLY_US_2 * `CLK_MHZ);
			3'h3: load_val = CW'(`DLY_US_3 * `CLK_MHZ);
			3'h4: load_val = CW'(`DLY_US_4 * `CLK_MHZ);
			3'h5: load_val = CW'(`DLY_US_5 * `CLK_MHZ);
			3'h6: load_val = CW'(`DLY_US_6 * `CLK_MHZ);
			3'h7: load_val = CW'(`DLY_US_7 * `CLK_MHZ);
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
		end else if (tif.load) begin
			cnt_q <= load_val;
		end else if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end
	assign tif.busy = (cnt_q != 16'h0000);

	// Code 001 must load 8 us worth of 40 ns cycles
	chk_delay_load: assert property (@(posedge pclk) disable iff (!presetn)
		tif.load && tif.code == 3'h1 |=> cnt_q == 16'h00C8) else $error("8 us load wrong");
endmodule

//--- logic/adc_mode_control.sv
// Purpose: Operating mode register with APB access and conversion sequencer
// Assumes: single channel index given on chan_sel; conversions end on conv_done
// Notes: register at byte address 4 x index
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "adc_mode_defines.svh"
module adc_mode_control
	import adc_mode_pkg::*;
(
	input wire logic pclk, // Clock, 25 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [3:0] chan_sel, // Active channel from sequencer
	input wire logic multi_chan, // More than one channel enabled
	input wire logic conv_done, // Filter produced a result
	output logic ref_enable, // Internal reference on
	output logic ref_out_drive, // Drive 2.5 V on reference_output_pin
	output logic osc_enable, // Internal oscillator on
	output logic clk_io_oe_n, // clock_io_pin output enable, low drives
	output logic clk_io_ext_in, // clock_io_pin used as clock input
	output logic xtal_enable, // Crystal amplifier on
	output logic filter_reset, // Filter restart pulse
	output logic result_ready_n, // Result ready, active low
	output logic settled_only, // Deliver settled results only
	output logic [2:0] op_mode, // Current operating mode
	output logic converting // Conversion or calibration running
);
	logic [15:0] mode_q;
	logic wr_hit;
	logic rd_hit;
	logic [3:0] last_chan_q;
	logic rdy_n_q;
	logic filt_rst_q;
	seq_state_t state_q;
	settle_timer_if tif ();

	settle_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.tif(tif)
	);

	// decode of the mode register word
	assign wr_hit = psel && penable && pwrite && paddr == `MODE_REG_ADDR;
	assign rd_hit = paddr == `MODE_REG_ADDR;
	assign pready = 1'b1; // Always answers in the access cycle
	assign pslverr = psel && penable && !rd_hit;

	// register with reset value; reserved read-only bits stay zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= `MODE_REG_RESET;
		end else if (wr_hit) begin
			mode_q <= pwdata[15:0] & `MODE_WRITE_MASK;
		end
	end

	// Read data registered on setup so it holds through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rd_hit ? {16'h0000, mode_q} : 32'h0000_0000;
		end
	end

	assign ref_enable = mode_q[`BIT_REF_EN];
	assign ref_out_drive = mode_q[`BIT_REF_EN];
	// settled output only with a single channel
	assign settled_only = mode_q[`BIT_SETTLED] && !multi_chan;
	assign op_mode = mode_q[`FLD_MODE_HI:`FLD_MODE_LO];
	assign clk_io_oe_n = mode_q[`FLD_CLK_HI:`FLD_CLK_LO] != CLK_INT_OUT;
	assign clk_io_ext_in = mode_q[`FLD_CLK_HI:`FLD_CLK_LO] == CLK_EXT;
	assign xtal_enable = mode_q[`FLD_CLK_HI:`FLD_CLK_LO] == CLK_XTAL;
	assign osc_enable = !mode_q[`FLD_CLK_HI];
	// Status outputs from their flops; converting decoded from the state
	assign filter_reset = filt_rst_q;
	assign result_ready_n = rdy_n_q;
	assign converting = (state_q == ST_SETTLE) || (state_q == ST_CONVERT);

	// filter restart one cycle after any write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_rst_q <= 1'b0;
		end else begin
			filt_rst_q <= wr_hit;
		end
	end

	// ready cleared on write; write wins over a finishing result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_n_q <= 1'b1;
		end else if (wr_hit) begin
			rdy_n_q <= 1'b1;
		end else if (state_q == ST_CONVERT && conv_done) begin
			rdy_n_q <= 1'b0;
		end
	end

	// delay only when channel changes or a run restarts
	// Every write that starts a conversion or calibration reloads the delay;
	// standby and power-down (mode 01x) leave the timer alone
	assign tif.load = (wr_hit && pwdata[6:5] != 2'b01)
		|| (state_q == ST_CONVERT && conv_done && chan_sel != last_chan_q);
	assign tif.code = wr_hit ? pwdata[`FLD_DELAY_HI:`FLD_DELAY_LO] : mode_q[`FLD_DELAY_HI:`FLD_DELAY_LO];

	// Channel of the last finished conversion, to spot a real switch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_chan_q <= 4'h0;
		end else if (state_q == ST_CONVERT && conv_done) begin
			last_chan_q <= chan_sel;
		end
	end

	// sequencer: standby and power-down idle, single and calibrations stop after one result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
		end else if (wr_hit) begin
			unique case (pwdata[6:4])
				MODE_STANDBY, MODE_PWRDN: state_q <= ST_IDLE;
				default: state_q <= ST_SETTLE;
			endcase
		end else begin
			unique case (state_q)
				ST_IDLE: state_q <= ST_IDLE;
				ST_SETTLE: begin
					if (!tif.busy) begin
						state_q <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (conv_done) begin
						state_q <= (op_mode == MODE_CONT) ? ST_SETTLE : ST_DONE;
					end
				end
				// Done lasts one cycle so the end of a run is visible
				ST_DONE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Named steps of a register write and of a finished conversion
	sequence s_write;
		wr_hit;
	endsequence
	sequence s_restart;
		filt_rst_q && rdy_n_q;
	endsequence
	sequence s_run_write;
		wr_hit && pwdata[6:5] != 2'b01;
	endsequence
	sequence s_result;
		state_q == ST_CONVERT && conv_done && !wr_hit;
	endsequence
	sequence s_same_chan_result;
		state_q == ST_CONVERT && conv_done && !wr_hit && op_mode == MODE_CONT && chan_sel == last_chan_q;
	endsequence

	// A write restarts the filter and clears ready one cycle later
	chk_write_restart: assert property (@(posedge pclk) disable iff (!presetn)
		s_write |=> s_restart) else $error("write did not restart");

	// A write that selects a running mode starts the settle step
	chk_run_start: assert property (@(posedge pclk) disable iff (!presetn)
		s_run_write |=> state_q == ST_SETTLE && converting) else $error("run not started");

	// A result taken in the convert step raises ready
	chk_ready_set: assert property (@(posedge pclk) disable iff (!presetn)
		s_result |=> !rdy_n_q) else $error("ready not raised");

	// Read-only reserved bits never hold a one
	chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_q & ~`MODE_WRITE_MASK) == 16'h0000) else $error("reserved bit set");

	// Register holds its reset word when reset lets go
	chk_reset_value: assert property (@(posedge pclk)
		$rose(presetn) |-> mode_q == `MODE_REG_RESET) else $error("bad reset value");

	// Reference output follows its enable bit
	chk_ref_follow: assert property (@(posedge pclk) disable iff (!presetn)
		ref_out_drive == mode_q[15]) else $error("reference mismatch");

	// Settled-only output needs the bit and a single channel
	chk_settled_bit: assert property (@(posedge pclk) disable iff (!presetn)
		settled_only |-> mode_q[13] && !multi_chan) else $error("settled misuse");

	// Standby and power-down start nothing
	chk_mode_idle: assert property (@(posedge pclk) disable iff (!presetn)
		wr_hit && pwdata[6:5] == 2'b01 |=> state_q == ST_IDLE) else $error("standby ran");

	// Clock pin driven only with the internal oscillator running
	chk_clock_pins: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_io_oe_n |-> osc_enable && !clk_io_ext_in) else $error("clock pin clash");

	// At most one use of the clock pins at a time
	chk_clock_onehot: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot0({!clk_io_oe_n, clk_io_ext_in, xtal_enable})) else $error("clock pins overlap");

	// Internal source keeps the oscillator on
	chk_osc_on: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q[3:2] == 2'b00 |-> osc_enable) else $error("oscillator off");

	// No conversion while the settle delay runs
	chk_settle_wait: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_SETTLE && tif.busy |=> state_q != ST_CONVERT) else $error("early convert");

	// Repeated results on one channel add no delay
	chk_same_chan: assert property (@(posedge pclk) disable iff (!presetn)
		s_same_chan_result |=> state_q == ST_SETTLE && !tif.busy) else $error("delay on same channel");
endmodule

//--- verif/adc_mode_control_test.sv
// Purpose: Self-checking bench for the mode control block over APB
// Assumes: pclk 40 ns, slave answers when pready is high
// Notes: expected values come from the field layout; reserved bits 12:11, 7, 1:0 read zero
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module adc_mode_control_test;
	import adc_mode_pkg::*;
	localparam logic [11:0] MODE_ADDR = 12'h004; // Index 0x01 times four
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic multi_chan = 1'b0, conv_done = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, rd, prdata;
	logic [3:0] chan_sel = 4'h0;
	logic [2:0] op_mode;
	logic pready, pslverr, ref_enable, ref_out_drive, osc_enable, clk_io_oe_n, clk_io_ext_in;
	logic xtal_enable, filter_reset, result_ready_n, settled_only, converting;
	int errors = 0, n_checks = 0;
	adc_mode_control u_adc_mode_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .chan_sel, .multi_chan, .conv_done, .ref_enable, .ref_out_drive,
		.osc_enable, .clk_io_oe_n, .clk_io_ext_in, .xtal_enable, .filter_reset, .result_ready_n,
		.settled_only, .op_mode, .converting);
	// Free-running 25 MHz clock
	initial begin
		forever #20 pclk = ~pclk;
	end
	// One APB transfer; an edge passes first so psel is never set twice in one step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Register write, then look once the write edge has landed
	task automatic wr(input logic [15:0] d);
		xfer(1'b1, MODE_ADDR, d);
		#1;
		`CHK("filter restart", 1'b1, filter_reset)
		`CHK("ready cleared", 1'b1, result_ready_n)
	endtask
	// Filter result pulse after a given wait
	task automatic pulse_done(input int n);
		repeat (n) @(posedge pclk);
		conv_done <= 1'b1;
		@(posedge pclk);
		conv_done <= 1'b0;
		@(posedge pclk);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard, far beyond the roughly 500 cycles the tests need
	initial begin
		#400000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, MODE_ADDR, 16'h0000);
		`CHK("reset value", 32'h00002000, rd)
		`CHK("osc after reset", 1'b1, osc_enable)
		`CHK("idle after reset", 1'b0, converting)
		`CHK("good access err", 1'b0, err)
		// Reserved read-only bits drop out, bit 14 is kept
		wr(16'hFFFF);
		@(posedge pclk);
		#1;
		`CHK("single pulse", 1'b0, filter_reset)
		xfer(1'b0, MODE_ADDR, 16'h0000);
		`CHK("all ones", 32'h0000E77C, rd)
		`CHK("reference", 2'b11, {ref_enable, ref_out_drive})
		wr(16'h0020);
		`CHK("reference off", 2'b00, {ref_enable, ref_out_drive})
		`CHK("settled off", 1'b0, settled_only)
		wr(16'h2020);
		`CHK("settled one chan", 1'b1, settled_only)
		@(posedge pclk);
		multi_chan <= 1'b1;
		#1;
		`CHK("settled multi", 1'b0, settled_only)
		@(posedge pclk);
		multi_chan <= 1'b0;
		// Every clock source, in standby so no sequencing runs
		for (int c = 0; c < 4; c++) begin
			wr(16'h2020 | 16'(c << 2));
			`CHK("osc on", c < 2, osc_enable)
			`CHK("clk io drive", c != 1, clk_io_oe_n)
			`CHK("clk io input", c == 2, clk_io_ext_in)
			`CHK("crystal", c == 3, xtal_enable)
		end
		// Every mode; standby and power-down start nothing
		for (int m = 7; m >= 0; m--) begin
			wr(16'h2000 | 16'(m << 4));
			`CHK("mode field", m[2:0], op_mode)
			`CHK("running", !(m == 2 || m == 3), converting)
		end
		// Unmapped addresses are refused and change nothing
		xfer(1'b1, 12'h000, 16'hFFFF);
		`CHK("bad write err", 1'b1, err)
		xfer(1'b0, 12'h008, 16'h0000);
		`CHK("bad read err", 1'b1, err)
		`CHK("bad read data", 32'h00000000, rd)
		xfer(1'b0, MODE_ADDR, 16'h0000);
		`CHK("unchanged", 32'h00002000, rd)
		// Code 001 holds off 8 us = 200 cycles; results inside it are ignored
		chan_sel <= 4'h3;
		wr(16'h2110);
		pulse_done(170);
		`CHK("early result", 1'b1, result_ready_n)
		pulse_done(40);
		`CHK("settled result", 1'b0, result_ready_n)
		`CHK("single done", 1'b0, converting)
		// continuous result read is never enabled; only the mode word is written
		// Continuous run on one channel: delay once after the write, none between results
		wr(16'h2100);
		pulse_done(205);
		`CHK("cont result", 1'b0, result_ready_n)
		pulse_done(2);
		`CHK("cont running", 1'b1, converting)
		wr(16'h2110);
		tally_and_finish();
	end
endmodule
